// ---- dv/lcdi2c_host_model.sv ----
// host bus master model: start, stop, byte write and byte read
// assumes: sda_in is the resolved wire with a pull-up; scl rests high between frames
module lcdi2c_host_model (
    output logic      scl_out,
    output logic      sda_low_out,
    input  wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic tick_r = 1'b0;

    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
        forever #3 tick_r = ~tick_r;
    end

    // quarter bit of 150 ns keeps setup and hold above six system cycles
    task automatic q();
        repeat (25) @(posedge tick_r);
    endtask

    // -------------------------------------------------------------------------
    // bus conditions and bits
    // -------------------------------------------------------------------------
    task automatic start_c();
        sda_low_out <= 1'b0;
        q();
        scl_out <= 1'b1;
        q();
        q();
        sda_low_out <= 1'b1;
        q();
        q();
        scl_out <= 1'b0;
        q();
    endtask

    task automatic stop_c();
        sda_low_out <= 1'b1;
        q();
        scl_out <= 1'b1;
        q();
        q();
        sda_low_out <= 1'b0;
        q();
        q();
    endtask

    task automatic put_bit(input logic b, output logic got);
        sda_low_out <= ~b;
        q();
        scl_out <= 1'b1;
        q();
        got = sda_in;
        q();
        scl_out <= 1'b0;
        q();
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack_n);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(d[i], g);
        put_bit(1'b1, ack_n);
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, g);
            d[i] = g;
        end
        put_bit(last, g);
    endtask
endmodule

// ---- dv/lcdi2c_slave_chk.sv ----
// checker for the i2c slave port, bound to every lcdi2c_slave
// assumes: clock_in samples everything; scl phases are long against clock_in
module lcdi2c_slave_chk (
    input wire logic       clock_in,
    input wire logic       rst_in,
    input wire logic       ce_in,
    input wire logic       scl_clk_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       selected_out,
    input wire logic [7:0] addr_out,
    input wire logic       wr_en_out,
    input wire logic       rd_en_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // -------------------------------------------------------------------------
    // pointer seen at the last write strobe
    // -------------------------------------------------------------------------
    logic [7:0] wr_addr_r;
    logic [7:0] wr_addr_nxt;
    always_comb wr_addr_nxt = wr_en_out ? addr_out : wr_addr_r;
    always_ff @(posedge clock_in) wr_addr_r <= wr_addr_nxt;

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    a_sda_value_low: assert property (sda_out == 1'b0)
        else $error("open drain value not low");
    a_reset_clears: assert property (disable iff (1'b0)
        rst_in |=> !sda_oe_out && !selected_out && addr_out == 8'h00 && !wr_en_out)
        else $error("outputs not cleared by reset");
    // a drive change with scl high would look like a start or stop
    a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
        else $error("sda drive changed while scl high");
    a_wr_one_cycle: assert property (wr_en_out |=> !wr_en_out)
        else $error("write strobe longer than one cycle");
    a_rd_one_cycle: assert property (rd_en_out |=> !rd_en_out)
        else $error("read strobe longer than one cycle");
    a_strobe_selected: assert property ((wr_en_out || rd_en_out) |-> selected_out)
        else $error("strobe while not selected");
    a_ce_gates_strobes: assert property (!ce_in |-> !wr_en_out && !rd_en_out)
        else $error("strobe while clock enable low");
    a_ptr_hold: assert property (wr_en_out |=> $stable(addr_out) [*4])
        else $error("pointer moved right after write");
    a_ptr_step: assert property (wr_en_out |-> ##[1:100] addr_out == wr_addr_r + 8'h01)
        else $error("pointer did not step by one");

    c_write: cover property (wr_en_out);
    c_read: cover property (rd_en_out);
    c_deselect: cover property ($fell(selected_out));
endmodule

bind lcdi2c_slave lcdi2c_slave_chk chk_u (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .scl_clk_in(scl_clk_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .selected_out(selected_out), .addr_out(addr_out), .wr_en_out(wr_en_out),
    .rd_en_out(rd_en_out)
);

// ---- dv/tb_top.sv ----
// self-checking bench for the i2c slave port with a host model and a user-side store
// assumes: design, checker and host model compiled before this file
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock_in;
    logic        rst_in;
    logic        ce_in;
    logic        scl;
    logic        sda_low;
    logic        sda_wire;
    logic        sda_out;
    logic        sda_oe_out;
    logic        selected_out;
    logic        space_out;
    logic [7:0]  addr_out;
    logic [7:0]  wdata_out;
    logic        wr_en_out;
    logic        rd_en_out;
    logic [7:0]  rd_data;
    logic [16:0] wq[$];
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          rd_cnt = 0;

    function automatic logic [7:0] dev_byte(input logic s, input logic [7:0] a);
        return {a[6:0], s} ^ 8'h5A;
    endfunction

    // pull-up: wire is low when either party pulls
    assign sda_wire = (sda_low || (sda_oe_out && !sda_out)) ? 1'b0 : 1'b1;
    assign rd_data  = dev_byte(space_out, addr_out);

    lcdi2c_host_model host_u (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_wire));

    lcdi2c_slave dut_u (
        .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .scl_clk_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .selected_out(selected_out), .space_out(space_out),
        .addr_out(addr_out), .wdata_out(wdata_out), .wr_en_out(wr_en_out), .rd_en_out(rd_en_out),
        .rd_data_in(rd_data)
    );

    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        if (wr_en_out === 1'b1) wq.push_back({space_out, addr_out, wdata_out});
        if (rd_en_out === 1'b1) rd_cnt++;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    // -------------------------------------------------------------------------
    // compare and bus helpers
    // -------------------------------------------------------------------------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_wr(input logic [16:0] exp);
        chk((wq.size() > 0) ? wq.pop_front() : 17'h1FFFF, exp);
    endtask

    task automatic send(input logic [7:0] d, input logic exp_n);
        logic a;
        host_u.wr_byte(d, a);
        chk({16'h0000, a}, {16'h0000, exp_n});
    endtask

    task automatic get(input logic last, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd_byte(last, d);
        chk({9'h000, d}, {9'h000, exp});
    endtask

    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    task automatic t_ctrl_write();
        host_u.start_c();
        send(8'h70, 1'b0);
        chk({16'h0000, selected_out}, 17'h00001);
        send(8'hFE, 1'b0);
        send(8'h11, 1'b0);
        send(8'h22, 1'b0);
        send(8'h33, 1'b0);
        host_u.stop_c();
        chk_wr({1'b0, 8'hFE, 8'h11});
        chk_wr({1'b0, 8'hFF, 8'h22});
        chk_wr({1'b0, 8'h00, 8'h33});
        chk({16'h0000, selected_out}, 17'h00000);
        $display("t_ctrl_write done");
    endtask

    task automatic t_disp_write();
        host_u.start_c();
        send(8'h72, 1'b0);
        send(8'h10, 1'b0);
        send(8'h5A, 1'b0);
        host_u.stop_c();
        chk_wr({1'b1, 8'h10, 8'h5A});
        $display("t_disp_write done");
    endtask

    task automatic t_read();
        host_u.start_c();
        send(8'h72, 1'b0);
        send(8'h20, 1'b0);
        host_u.start_c();
        send(8'h73, 1'b0);
        get(1'b0, dev_byte(1'b1, 8'h20));
        get(1'b0, dev_byte(1'b1, 8'h21));
        get(1'b1, dev_byte(1'b1, 8'h22));
        chk({15'h0000, sda_oe_out, selected_out}, 17'h00000);
        host_u.stop_c();
        chk(17'(wq.size()), 17'h00000);
        // direct read of the control space from the pointer left by the nack
        host_u.start_c();
        send(8'h71, 1'b0);
        get(1'b1, dev_byte(1'b0, 8'h22));
        host_u.stop_c();
        chk(17'(rd_cnt), 17'h00004);
        $display("t_read done");
    endtask

    task automatic t_foreign();
        host_u.start_c();
        send(8'h74, 1'b1);
        send(8'h00, 1'b1);
        host_u.stop_c();
        chk({15'h0000, selected_out, sda_oe_out}, 17'h00000);
        chk(17'(wq.size()), 17'h00000);
        $display("t_foreign done");
    endtask

    task automatic t_reset_recover();
        host_u.start_c();
        send(8'h70, 1'b0);
        send(8'h40, 1'b0);
        @(posedge clock_in) rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        chk({7'h00, selected_out, sda_oe_out, addr_out}, 17'h00000);
        host_u.stop_c();
        @(posedge clock_in) ce_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        ce_in <= 1'b1;
        $display("t_reset_recover done");
    endtask

    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        rst_in = 1'b1;
        ce_in  = 1'b1;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        t_ctrl_write();
        t_disp_write();
        t_read();
        t_foreign();
        t_reset_recover();
        t_ctrl_write();
        wrap_up();
    end
endmodule

// ---- hw/lcdi2c_defines.svh ----
// constants of the lcd controller i2c slave port: addresses, field positions, reset values
// assumes: included by its bare name from the lcdi2c_slave design module
`ifndef LCDI2C_DEFINES_SVH
`define LCDI2C_DEFINES_SVH

// -----------------------------------------------------------------------------
// slave addresses (7 bit)
// -----------------------------------------------------------------------------
`define LCDI2C_ADDR_CTRL      7'h38
`define LCDI2C_ADDR_DISP      7'h39

// -----------------------------------------------------------------------------
// field positions within a received address byte and its 7-bit address
// -----------------------------------------------------------------------------
`define LCDI2C_ADDR_MSB       7
`define LCDI2C_ADDR_LSB       1
`define LCDI2C_DIR_BIT        0
`define LCDI2C_SPACE_BIT      0

// -----------------------------------------------------------------------------
// widths, counts and reset values
// -----------------------------------------------------------------------------
`define LCDI2C_BYTE_W         8
`define LCDI2C_CNT_W          4
`define LCDI2C_DATA_BIT_LAST  4'h8
`define LCDI2C_ACK_CLOCK      4'h9
`define LCDI2C_CNT_RST        4'h0
`define LCDI2C_PTR_RST        8'h00
`define LCDI2C_BYTE_RST       8'h00
`define LCDI2C_PTR_STEP       8'h01

`endif

// ---- hw/lcdi2c_link_rx.sv ----
// serial capture register running on the bus clock itself
// assumes: the bus clock may stop between frames; the word is read by the system
// domain only while the bus clock is high after a counted rising edge
module lcdi2c_link_rx
    import lcdi2c_pkg::*;
(
    input  wire logic       scl_clk_in,
    input  wire logic       sda_in,
    output logic [7:0]      word_out
);

    logic [7:0] shift_r;
    logic [7:0] shift_nxt;

    // -------------------------------------------------------------------------
    // shift on every rising bus clock edge
    // -------------------------------------------------------------------------
    // no reset: pure data, framed by the system-domain bit counter
    always_comb begin
        shift_nxt = {shift_r[6:0], sda_in};
    end

    always_ff @(posedge scl_clk_in) begin
        shift_r <= shift_nxt;
    end

    assign word_out = shift_r;

endmodule

// ---- hw/lcdi2c_pkg.sv ----
// types shared by the lcd controller i2c slave port
// assumes: compiled before the design modules
package lcdi2c_pkg;

    // -------------------------------------------------------------------------
    // protocol phase of the slave engine
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        LCDI2C_IDLE   = 3'b000,
        LCDI2C_RX_ID  = 3'b001,
        LCDI2C_RX_REG = 3'b010,
        LCDI2C_RX_DAT = 3'b011,
        LCDI2C_TX_DAT = 3'b100
    } lcdi2c_state_t;

    // -------------------------------------------------------------------------
    // target space chosen by the slave address
    // -------------------------------------------------------------------------
    typedef enum logic {
        LCDI2C_SPACE_CTRL = 1'b0,
        LCDI2C_SPACE_DISP = 1'b1
    } lcdi2c_space_t;

endpackage

// ---- hw/lcdi2c_slave.sv ----
// lcd controller i2c slave port: protocol engine and user-side access strobes
// assumes: bus pins arrive asynchronously; the user side answers rd_data_in
// combinationally from space_out and addr_out
`include "lcdi2c_defines.svh"

module lcdi2c_slave
    import lcdi2c_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       scl_clk_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            selected_out,
    output logic            space_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      wdata_out,
    output logic            wr_en_out,
    output logic            rd_en_out,
    input  wire logic [7:0] rd_data_in
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    logic                       scl_f_r;
    logic                       scl_f_nxt;
    logic                       sda_f_r;
    logic                       sda_f_nxt;
    lcdi2c_state_t              state_r;
    lcdi2c_state_t              state_nxt;
    logic [`LCDI2C_CNT_W-1:0]   cnt_r;
    logic [`LCDI2C_CNT_W-1:0]   cnt_nxt;
    logic                       ack_pend_r;
    logic                       ack_pend_nxt;
    logic                       dir_r;
    logic                       dir_nxt;
    logic                       space_r;
    logic                       space_nxt;
    logic [7:0]                 ptr_r;
    logic [7:0]                 ptr_nxt;
    logic [7:0]                 wdata_r;
    logic [7:0]                 wdata_nxt;
    logic [7:0]                 tx_r;
    logic [7:0]                 tx_nxt;
    logic                       oe_r;
    logic                       oe_nxt;
    logic                       wr_r;
    logic                       wr_nxt;
    logic                       rd_r;
    logic                       rd_nxt;
    logic                       sel_r;
    logic                       sel_nxt;

    logic [7:0]                 link_word;
    logic [1:0]                 pin_raw;
    wire  [1:0]                 pin_lvl;
    wire  [1:0]                 pin_lvl_nxt;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       sda_rise;
    logic                       sda_fall;
    logic                       start_det;
    logic                       stop_det;
    logic [6:0]                 id_rx;

    // -------------------------------------------------------------------------
    // bus clock domain capture
    // -------------------------------------------------------------------------
    // the word crosses without a synchroniser: it is read only on a filtered
    // rising edge, a few system cycles after the bus edge that shifted it, and
    // it then holds until the next bus rising edge, far later
    lcdi2c_link_rx u_link_rx (
        .scl_clk_in (scl_clk_in),
        .sda_in     (sda_in),
        .word_out   (link_word)
    );

    // -------------------------------------------------------------------------
    // pin filtering and condition detection
    // -------------------------------------------------------------------------
    // bit 0 is the clock line, bit 1 the data line; both get the same filter
    assign pin_raw = {sda_in, scl_clk_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            logic [2:0] sync_r;
            logic [2:0] sync_nxt;
            logic       lvl_r;
            logic       lvl_nxt;

            // a level is taken only when stages two and three agree, which
            // also hides a single-cycle glitch on either line
            always_comb begin
                sync_nxt = {sync_r[1:0], pin_raw[gi]};
                lvl_nxt  = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
            end

            // preset high like the idle bus, so release gives no false edge
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    sync_r <= 3'h7;
                    lvl_r  <= 1'b1;
                end else if (ce_in) begin
                    sync_r <= sync_nxt;
                    lvl_r  <= lvl_nxt;
                end
            end

            assign pin_lvl[gi]     = lvl_r;
            assign pin_lvl_nxt[gi] = lvl_nxt;
        end
    endgenerate

    assign scl_f_r   = pin_lvl[0];
    assign scl_f_nxt = pin_lvl_nxt[0];
    assign sda_f_r   = pin_lvl[1];
    assign sda_f_nxt = pin_lvl_nxt[1];

    assign scl_rise  = scl_f_nxt & ~scl_f_r;
    assign scl_fall  = ~scl_f_nxt & scl_f_r;
    assign sda_rise  = sda_f_nxt & ~sda_f_r;
    assign sda_fall  = ~sda_f_nxt & sda_f_r;
    assign start_det = sda_fall & scl_f_r & scl_f_nxt;
    assign stop_det  = sda_rise & scl_f_r & scl_f_nxt;
    assign id_rx     = link_word[`LCDI2C_ADDR_MSB:`LCDI2C_ADDR_LSB];

    // -------------------------------------------------------------------------
    // protocol engine
    // -------------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        ack_pend_nxt = ack_pend_r;
        dir_nxt      = dir_r;
        space_nxt    = space_r;
        ptr_nxt      = ptr_r;
        wdata_nxt    = wdata_r;
        tx_nxt       = tx_r;
        oe_nxt       = oe_r;
        wr_nxt       = 1'b0;
        rd_nxt       = 1'b0;

        if (start_det) begin
            // a start, repeated or not, always restarts address reception
            state_nxt    = LCDI2C_RX_ID;
            cnt_nxt      = `LCDI2C_CNT_RST;
            ack_pend_nxt = 1'b0;
            oe_nxt       = 1'b0;
        end else if (stop_det) begin
            state_nxt    = LCDI2C_IDLE;
            cnt_nxt      = `LCDI2C_CNT_RST;
            ack_pend_nxt = 1'b0;
            oe_nxt       = 1'b0;
        end else if (state_r != LCDI2C_IDLE) begin
            if (scl_rise) begin
                cnt_nxt = cnt_r + `LCDI2C_CNT_W'(1);
                if (cnt_nxt == `LCDI2C_DATA_BIT_LAST && state_r != LCDI2C_TX_DAT) begin
                    case (state_r)
                        LCDI2C_RX_ID: begin
                            if (id_rx == `LCDI2C_ADDR_CTRL || id_rx == `LCDI2C_ADDR_DISP) begin
                                ack_pend_nxt = 1'b1;
                                dir_nxt      = link_word[`LCDI2C_DIR_BIT];
                                space_nxt    = id_rx[`LCDI2C_SPACE_BIT];
                            end else begin
                                state_nxt = LCDI2C_IDLE;
                            end
                        end
                        LCDI2C_RX_REG: begin
                            ptr_nxt      = link_word;
                            ack_pend_nxt = 1'b1;
                        end
                        LCDI2C_RX_DAT: begin
                            wdata_nxt    = link_word;
                            wr_nxt       = 1'b1;
                            ack_pend_nxt = 1'b1;
                        end
                        default: begin
                            state_nxt = LCDI2C_IDLE;
                        end
                    endcase
                end else if (cnt_nxt == `LCDI2C_ACK_CLOCK) begin
                    if (state_r == LCDI2C_TX_DAT) begin
                        if (sda_f_r) begin
                            // no acknowledge from the master: transfer is over
                            state_nxt = LCDI2C_IDLE;
                            oe_nxt    = 1'b0;
                        end else begin
                            ptr_nxt = ptr_r + `LCDI2C_PTR_STEP;
                        end
                    end else if (state_r == LCDI2C_RX_DAT) begin
                        ptr_nxt = ptr_r + `LCDI2C_PTR_STEP;
                    end
                end
            end else if (scl_fall) begin
                if (cnt_r == `LCDI2C_DATA_BIT_LAST) begin
                    // drive the acknowledge only while scl is low, so it is
                    // stable across the whole high phase of clock nine
                    oe_nxt = (state_r == LCDI2C_TX_DAT) ? 1'b0 : ack_pend_r;
                end else if (cnt_r == `LCDI2C_ACK_CLOCK) begin
                    cnt_nxt      = `LCDI2C_CNT_RST;
                    ack_pend_nxt = 1'b0;
                    oe_nxt       = 1'b0;
                    case (state_r)
                        LCDI2C_RX_ID: begin
                            if (dir_r) begin
                                state_nxt = LCDI2C_TX_DAT;
                                tx_nxt    = rd_data_in;
                                rd_nxt    = 1'b1;
                                oe_nxt    = ~rd_data_in[7];
                            end else begin
                                state_nxt = LCDI2C_RX_REG;
                            end
                        end
                        LCDI2C_RX_REG: begin
                            state_nxt = LCDI2C_RX_DAT;
                        end
                        LCDI2C_TX_DAT: begin
                            tx_nxt = rd_data_in;
                            rd_nxt = 1'b1;
                            oe_nxt = ~rd_data_in[7];
                        end
                        default: begin
                            state_nxt = state_r;
                        end
                    endcase
                end else if (state_r == LCDI2C_TX_DAT && cnt_r != `LCDI2C_CNT_RST) begin
                    // bit 7 went out at the fall that opened the byte
                    oe_nxt = ~tx_r[3'(7 - cnt_r)];
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // selection status
    // -------------------------------------------------------------------------
    // taken from the next state so the registered flag matches the engine in
    // the same cycle; during an address byte it rises only on clock nine
    always_comb begin
        sel_nxt = (state_nxt != LCDI2C_IDLE) &&
                  (state_nxt != LCDI2C_RX_ID || cnt_nxt == `LCDI2C_ACK_CLOCK);
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_r    <= LCDI2C_IDLE;
            cnt_r      <= `LCDI2C_CNT_RST;
            ack_pend_r <= 1'b0;
            dir_r      <= 1'b0;
            space_r    <= LCDI2C_SPACE_CTRL;
            ptr_r      <= `LCDI2C_PTR_RST;
            wdata_r    <= `LCDI2C_BYTE_RST;
            tx_r       <= `LCDI2C_BYTE_RST;
            oe_r       <= 1'b0;
            wr_r       <= 1'b0;
            rd_r       <= 1'b0;
            sel_r      <= 1'b0;
        end else if (ce_in) begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            ack_pend_r <= ack_pend_nxt;
            dir_r      <= dir_nxt;
            space_r    <= space_nxt;
            ptr_r      <= ptr_nxt;
            wdata_r    <= wdata_nxt;
            tx_r       <= tx_nxt;
            oe_r       <= oe_nxt;
            wr_r       <= wr_nxt;
            rd_r       <= rd_nxt;
            sel_r      <= sel_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    // only the data line is ever driven, and only low
    assign sda_out      = 1'b0;
    assign sda_oe_out   = oe_r;
    assign selected_out = sel_r;
    assign space_out    = space_r;
    assign addr_out     = ptr_r;
    assign wdata_out    = wdata_r;
    assign wr_en_out    = wr_r & ce_in;
    assign rd_en_out    = rd_r & ce_in;

endmodule
